// *** common/utcc_defs.vh ***
// Register offsets, field positions, reset values and timing constants of the capture/compare timer
`ifndef UTCC_DEFS_VH
`define UTCC_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UTCC_OFS_CONTROL_ONE 8'h00
`define UTCC_OFS_CHAN_CTRL 8'h04
`define UTCC_OFS_IRQ_ENABLE 8'h0C
`define UTCC_OFS_STATUS 8'h10
`define UTCC_OFS_EVENT_GEN 8'h14
`define UTCC_OFS_COUNTER 8'h24
`define UTCC_OFS_PRESCALE 8'h28
`define UTCC_OFS_RELOAD 8'h2C
`define UTCC_OFS_CAPCMP 8'h34
// ----------------------------------------
// control_one fields
// ----------------------------------------
`define UTCC_CR_CEN 0
`define UTCC_CR_UPDATE_SUPPRESS 1
`define UTCC_CR_URS 2
`define UTCC_CR_RELOAD_BUFFER_ENABLE 7
`define UTCC_CR_CKD_LO 8
`define UTCC_CR_CKD_HI 9
// ----------------------------------------
// Channel control fields
// ----------------------------------------
`define UTCC_CH_DIR_LO 0
`define UTCC_CH_DIR_HI 1
`define UTCC_CH_PSC_LO 2
`define UTCC_CH_PSC_HI 3
`define UTCC_CH_FLT_LO 4
`define UTCC_CH_FLT_HI 7
`define UTCC_CH_MODE_LO 8
`define UTCC_CH_MODE_HI 11
`define UTCC_CH_CCE 12
`define UTCC_CH_POLA 13
`define UTCC_CH_POLB 14
// ----------------------------------------
// Status / event / enable bits
// ----------------------------------------
`define UTCC_SR_UIF 0
`define UTCC_SR_CCIF 1
`define UTCC_SR_CCOF 9
`define UTCC_EG_UG 0
`define UTCC_EG_CCG 1
`define UTCC_IE_CCIE 1
// ----------------------------------------
// Encodings, reset values, timing
// ----------------------------------------
`define UTCC_DIR_OUTPUT 2'h0
`define UTCC_MODE_FORCE_LOW 4'h4
`define UTCC_MODE_FORCE_HIGH 4'h5
`define UTCC_FLT_N8 4'h3
`define UTCC_FLT_N8_COUNT 4'h8
`define UTCC_RELOAD_RESET 16'hFFFF
`define UTCC_CEN_DELAY_CYCLES 1
`endif

// *** core/utcc_timer.v ***
// Up-counting timer with one capture/compare channel and a plain register port
//
// Chosen here: the address map and the address-and-strobe port.
`include "utcc_defs.vh"

// Functional notes
// - 16-bit up-counter paired with an auto-reload limit register.
// - Counter, prescaler and reload readable and writable at any time.
// - Reload accesses hit preload; shadow follows it or loads at update when buffered.
// - Overflow makes an update unless suppressed; update-generate bit requests one too.
// - Counter steps on prescaler tick only while enabled, one cycle after enable.
// - 16-bit prescaler divides by 1 to 65536; new ratio applies at update.
// - Counter runs zero to active reload, wraps to zero, signals overflow.
// - With suppress set, no update occurs; prescaler buffer and buffered reload shadow keep their values.
// - Software update while suppressed still restarts counter and prescaler, ratio kept.
// - With source select set, software update does not set update flag.
// - Update loads reload shadow, prescaler buffer and sets flag per source select.
// - Software sees capture/compare preload; capture fills shadow, compare uses shadow.
// - Input sampled, filtered, edge-selected and prescaled before triggering capture.
// - Qualified edge latches counter into capture register and sets channel flag.
// - Capture while channel flag still set raises the overcapture flag.
// - Channel flag clears by zero write or data read; overcapture only by zero write.
// - Nonzero direction makes channel input and capture register read-only.
// - Filter 0011 accepts a level after 8 consecutive equal samples.
// - Polarity 00 captures rising edges; prescale 00 every edge; needs capture enable.
// - Channel event-generate bit raises a software capture request.
// - Mode 0101 forces reference high, 0100 low; output inverted for active low.
// - While forced, compare against counter still sets channel flag and request.
// - Filter sample period is 1, 2 or 4 clocks for divider 00, 01, 10.
module utcc_timer (
  input wire clk, // 250 MHz timer clock
  input wire rst_n, // Synchronous reset, active low
  input wire [7:0] reg_addr, // Register byte address
  input wire [31:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [31:0] reg_rdata, // Read data, valid the cycle after reg_rd
  input wire capture_pin, // Asynchronous capture input
  output reg channel_output, // Compare output after polarity
  output reg update_event, // One-cycle pulse on each update
  output reg channel_irq // Channel request level: flag and enable
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [15:0] control_one;
  reg [14:0] chan_ctrl;
  reg [1:0] irq_enable;
  reg update_flag;
  reg channel_event_flag;
  reg overcapture_flag;
  reg [15:0] counter_value;
  reg [15:0] prescale_divider;
  reg [15:0] prescale_buffer;
  reg [15:0] prescale_count;
  reg [15:0] reload_limit;
  reg [15:0] reload_shadow;
  reg [15:0] capcmp_preload;
  reg [15:0] capcmp_shadow;
  reg count_run;
  reg pin_meta;
  reg pin_sync;
  reg [1:0] sample_div;
  reg [3:0] flt_count;
  reg filtered_input;
  reg filtered_prev;
  reg [2:0] capture_div;
  reg compare_reference;

  wire update_suppress = control_one[`UTCC_CR_UPDATE_SUPPRESS];
  wire update_source_select = control_one[`UTCC_CR_URS];
  wire reload_buffer_enable = control_one[`UTCC_CR_RELOAD_BUFFER_ENABLE];
  wire [1:0] sample_clock_divider = control_one[`UTCC_CR_CKD_HI:`UTCC_CR_CKD_LO];
  wire [1:0] channel_direction_select = chan_ctrl[`UTCC_CH_DIR_HI:`UTCC_CH_DIR_LO];
  wire [1:0] input_prescale_sel = chan_ctrl[`UTCC_CH_PSC_HI:`UTCC_CH_PSC_LO];
  wire [3:0] input_filter_sel = chan_ctrl[`UTCC_CH_FLT_HI:`UTCC_CH_FLT_LO];
  wire [3:0] compare_mode_sel = chan_ctrl[`UTCC_CH_MODE_HI:`UTCC_CH_MODE_LO];
  wire capture_enable = chan_ctrl[`UTCC_CH_CCE];
  wire edge_polarity_a = chan_ctrl[`UTCC_CH_POLA];
  wire edge_polarity_b = chan_ctrl[`UTCC_CH_POLB];
  wire is_input = channel_direction_select != `UTCC_DIR_OUTPUT;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Filter length in samples; other filter codes fall back to a single sample
  function [3:0] flt_len;
    input [3:0] sel;
    begin
      if (sel == `UTCC_FLT_N8)
        flt_len = `UTCC_FLT_N8_COUNT;
      else
        flt_len = 4'h1;
    end
  endfunction

  // Edges needed per capture: 1, 2, 4 or 8
  function [2:0] psc_last;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: psc_last = 3'h0;
        2'h1: psc_last = 3'h1;
        2'h2: psc_last = 3'h3;
        default: psc_last = 3'h7;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  // count_run lags the enable bit by one clock, so the first tick comes a cycle after the write
  wire count_tick = count_run && prescale_count == prescale_buffer;
  wire overflow = count_tick && counter_value >= reload_shadow;
  wire ug_write = reg_wr && reg_addr == `UTCC_OFS_EVENT_GEN && reg_wdata[`UTCC_EG_UG];
  wire next_update = (overflow || ug_write) && !update_suppress;
  wire restart = ug_write;

  // ----------------------------------------
  // Input stage
  // ----------------------------------------
  wire sample_en = sample_div == 2'h0;
  wire [1:0] div_last = sample_clock_divider == 2'h1 ? 2'h1 : (sample_clock_divider == 2'h2 ? 2'h3 : 2'h0);
  // Both polarity bits set selects either edge
  wire rise = filtered_input && !filtered_prev;
  wire fall = !filtered_input && filtered_prev;
  wire edge_qualified_input = (edge_polarity_a && edge_polarity_b) ? (rise || fall) :
                              (edge_polarity_a ? fall : rise);
  wire capture_fire = is_input && capture_enable && edge_qualified_input
                      && capture_div == psc_last(input_prescale_sel);
  wire ccg_write = reg_wr && reg_addr == `UTCC_OFS_EVENT_GEN && reg_wdata[`UTCC_EG_CCG];
  wire compare_hit = !is_input && count_tick && counter_value == capcmp_shadow;
  wire chan_set = capture_fire || ccg_write || compare_hit;
  wire sr_write = reg_wr && reg_addr == `UTCC_OFS_STATUS;
  wire ccr_read = reg_rd && reg_addr == `UTCC_OFS_CAPCMP;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      control_one <= 16'h0000;
      chan_ctrl <= 15'h0000;
      irq_enable <= 2'h0;
      prescale_divider <= 16'h0000;
      reload_limit <= `UTCC_RELOAD_RESET;
      count_run <= 1'b0;
      update_event <= 1'b0;
    end
    else
    begin
      count_run <= control_one[`UTCC_CR_CEN];
      update_event <= next_update;
      if (reg_wr)
      begin
        // Unused control_one bits are masked so they always read zero
        case (reg_addr)
          `UTCC_OFS_CONTROL_ONE: control_one <= reg_wdata[15:0] & 16'h0387;
          `UTCC_OFS_CHAN_CTRL: chan_ctrl <= reg_wdata[14:0];
          `UTCC_OFS_IRQ_ENABLE: irq_enable <= reg_wdata[1:0];
          `UTCC_OFS_PRESCALE: prescale_divider <= reg_wdata[15:0];
          `UTCC_OFS_RELOAD: reload_limit <= reg_wdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      prescale_count <= 16'h0000;
      counter_value <= 16'h0000;
    end
    else
    begin
      // A counter write beats restart and wrap, so software reads back what it wrote
      if (restart || count_tick)
        prescale_count <= 16'h0000;
      else if (count_run)
        prescale_count <= prescale_count + 16'h0001;
      if (reg_wr && reg_addr == `UTCC_OFS_COUNTER)
        counter_value <= reg_wdata[15:0];
      else if (restart || overflow)
        counter_value <= 16'h0000;
      else if (count_tick)
        counter_value <= counter_value + 16'h0001;
    end
  end

  // ----------------------------------------
  // Time base shadows
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      prescale_buffer <= 16'h0000;
      reload_shadow <= `UTCC_RELOAD_RESET;
    end
    else
    begin
      // The ratio only moves at an update, so a running period is never cut short
      if (next_update)
        prescale_buffer <= prescale_divider;
      if (!reload_buffer_enable)
        reload_shadow <= reload_limit;
      else if (next_update)
        reload_shadow <= reload_limit;
    end
  end

  // ----------------------------------------
  // Capture/compare preload and shadow
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      capcmp_preload <= 16'h0000;
      capcmp_shadow <= 16'h0000;
    end
    else
    begin
      // Read-only as an input, so a stray write cannot spoil a captured value
      if (!is_input)
      begin
        capcmp_shadow <= capcmp_preload;
        if (reg_wr && reg_addr == `UTCC_OFS_CAPCMP)
          capcmp_preload <= reg_wdata[15:0];
      end
      else if (capture_fire)
      begin
        capcmp_shadow <= counter_value;
        capcmp_preload <= counter_value;
      end
    end
  end

  // ----------------------------------------
  // Update flag
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      update_flag <= 1'b0;
    end
    else
    begin
      // A set in the same cycle as a clear wins
      if (next_update && !(ug_write && update_source_select))
        update_flag <= 1'b1;
      else if (sr_write && !reg_wdata[`UTCC_SR_UIF])
        update_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Channel flags
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      channel_event_flag <= 1'b0;
      overcapture_flag <= 1'b0;
    end
    else
    begin
      // Set wins over a clear, so an event never slips past a read of the data
      if (chan_set)
        channel_event_flag <= 1'b1;
      else if ((sr_write && !reg_wdata[`UTCC_SR_CCIF]) || ccr_read)
        channel_event_flag <= 1'b0;
      if (capture_fire && channel_event_flag)
        overcapture_flag <= 1'b1;
      else if (sr_write && !reg_wdata[`UTCC_SR_CCOF])
        overcapture_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Capture input: synchroniser, filter, edge and prescaler
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      sample_div <= 2'h0;
      flt_count <= 4'h0;
      filtered_input <= 1'b0;
      filtered_prev <= 1'b0;
      capture_div <= 3'h0;
    end
    else
    begin
      pin_meta <= capture_pin;
      pin_sync <= pin_meta;
      sample_div <= (sample_div >= div_last) ? 2'h0 : sample_div + 2'h1;
      filtered_prev <= filtered_input;
      if (sample_en)
      begin
        // Count samples at the new level; a bounce back restarts the run
        if (pin_sync == filtered_input)
          flt_count <= 4'h0;
        else if (flt_count + 4'h1 >= flt_len(input_filter_sel))
        begin
          filtered_input <= pin_sync;
          flt_count <= 4'h0;
        end
        else
          flt_count <= flt_count + 4'h1;
      end
      if (!is_input || !capture_enable)
        capture_div <= 3'h0;
      else if (edge_qualified_input)
        capture_div <= capture_fire ? 3'h0 : capture_div + 3'h1;
    end
  end

  // ----------------------------------------
  // Output stage and read port
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      compare_reference <= 1'b0;
      channel_output <= 1'b0;
      channel_irq <= 1'b0;
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      // Other compare modes are outside this block and hold the reference
      if (compare_mode_sel == `UTCC_MODE_FORCE_HIGH)
        compare_reference <= 1'b1;
      else if (compare_mode_sel == `UTCC_MODE_FORCE_LOW)
        compare_reference <= 1'b0;
      channel_output <= compare_reference ^ edge_polarity_a;
      channel_irq <= channel_event_flag && irq_enable[`UTCC_IE_CCIE];
      reg_rdata <= 32'h00000000;
      if (reg_rd)
      begin
        case (reg_addr)
          `UTCC_OFS_CONTROL_ONE: reg_rdata <= {16'h0000, control_one};
          `UTCC_OFS_CHAN_CTRL: reg_rdata <= {17'h00000, chan_ctrl};
          `UTCC_OFS_IRQ_ENABLE: reg_rdata <= {30'h00000000, irq_enable};
          `UTCC_OFS_STATUS: reg_rdata <= {22'h000000, overcapture_flag, 7'h00, channel_event_flag, update_flag};
          `UTCC_OFS_COUNTER: reg_rdata <= {16'h0000, counter_value};
          `UTCC_OFS_PRESCALE: reg_rdata <= {16'h0000, prescale_divider};
          `UTCC_OFS_RELOAD: reg_rdata <= {16'h0000, reload_limit};
          `UTCC_OFS_CAPCMP: reg_rdata <= {16'h0000, capcmp_preload};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // utcc_timer

// *** verif/up_timer_capture_compare_bench.sv ***
// Self-checking bench for the capture/compare timer
module up_timer_capture_compare_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d, c0;
  wire capture_pin, channel_output, update_event, channel_irq;
  int err_count = 0, checked = 0, n, ue;
  // Address, write data, expected read back
  logic [71:0] rows [0:9] = '{72'h0C_FFFFFFFF_00000003, 72'h08_FFFFFFFF_00000000, 72'h14_00000000_00000000,
    72'h04_00007FFF_00007FFF, 72'h34_0000ABCD_00000000, 72'h04_00000000_00000000, 72'h34_0001ABCD_0000ABCD,
    72'h28_00010003_00000003, 72'h2C_00010009_00000009, 72'h00_FFFFFFFF_00000387};
  logic [19:0] fz [0:3] = '{20'h05001, 20'h04000, 20'h25000, 20'h24001};
  utcc_timer dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .capture_pin, .channel_output, .update_event, .channel_irq);
  utcc_pin_model pin (.clk, .capture_pin, .channel_output);
  initial forever #2 clk = ~clk;
  always @(negedge clk) if (update_event === 1'h1) ue++;
  // ----
  // Tasks
  // ----
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  // Cycles between two update pulses
  task per(input logic [31:0] e);
    @(negedge clk);
    n = 0;
    while (update_event !== 1'h1 && n < 999)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (update_event !== 1'h1 && n < 999);
    chk("period", e, n);
  endtask
  task results;
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    foreach (rows[i])
    begin
      wr(rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64]);
      chk("register", rows[i][31:0], d);
    end
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h1);
    per(32'd40);
    rd(8'h10);
    chk("update flag", 32'h1, d & 32'h1);
    wr(8'h00, 32'h3);
    wr(8'h28, 32'h0);
    ue = 0;
    wr(8'h14, 32'h1);
    repeat (8) @(posedge clk);
    rd(8'h24);
    chk("restart", 32'h1, d < 32'h4);
    repeat (100) @(posedge clk);
    chk("suppressed", 32'h0, ue);
    wr(8'h2C, 32'hFFFF);
    wr(8'h00, 32'h5);
    wr(8'h10, 32'h0);
    ue = 0;
    wr(8'h14, 32'h1);
    rd(8'h10);
    chk("source select", 32'h0, d & 32'h1);
    chk("sw update", 32'h1, ue);
    wr(8'h00, 32'h1);
    wr(8'h14, 32'h1);
    rd(8'h10);
    chk("update flag", 32'h1, d & 32'h1);
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h1031);
    pin.drive(1'h1, 5);
    pin.drive(1'h0, 20);
    rd(8'h10);
    chk("glitch", 32'h0, d & 32'h202);
    rd(8'h24);
    c0 = d;
    pin.drive(1'h1, 30);
    chk("request", 32'h1, channel_irq);
    rd(8'h34);
    chk("capture", 32'h1, d > c0 && d < c0 + 32'h40);
    rd(8'h10);
    chk("read clears", 32'h0, d & 32'h202);
    pin.drive(1'h0, 30);
    rd(8'h10);
    chk("falling", 32'h0, d & 32'h2);
    pin.drive(1'h1, 30);
    pin.drive(1'h0, 30);
    pin.drive(1'h1, 30);
    rd(8'h10);
    chk("overcapture", 32'h202, d & 32'h202);
    rd(8'h34);
    rd(8'h10);
    chk("over kept", 32'h200, d & 32'h202);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h2);
    rd(8'h10);
    chk("event generate", 32'h2, d & 32'h202);
    wr(8'h00, 32'h201);
    wr(8'h10, 32'h0);
    pin.drive(1'h0, 60);
    pin.drive(1'h1, 20);
    pin.drive(1'h0, 60);
    rd(8'h10);
    chk("slow filter", 32'h0, d & 32'h2);
    pin.drive(1'h1, 60);
    rd(8'h10);
    chk("slow capture", 32'h2, d & 32'h2);
    foreach (fz[i])
    begin
      wr(8'h04, {16'h0, fz[i][19:4]});
      repeat (3) @(posedge clk);
      #1 chk("forced", {31'h0, fz[i][0]}, channel_output);
    end
    wr(8'h2C, 32'h20);
    wr(8'h34, 32'h10);
    wr(8'h24, 32'h0);
    wr(8'h10, 32'h0);
    rd(8'h10);
    chk("early match", 32'h0, d & 32'h2);
    repeat (80) @(posedge clk);
    rd(8'h10);
    chk("forced compare", 32'h2, d & 32'h2);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rd(8'h2C);
    chk("reload reset", 32'hFFFF, d);
    rd(8'h00);
    chk("control reset", 32'h0, d);
    results();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end
endmodule // up_timer_capture_compare_bench

// *** verif/utcc_pin_model.sv ***
// Far-side model: drives the capture pin, receives the compare output
module utcc_pin_model (
  input wire clk, // Timer clock
  output logic capture_pin, // Pin toward the timer
  input wire channel_output // Pin from the timer
);
  timeunit 1ns;
  timeprecision 1ps;
  initial capture_pin = 1'h0;
  // Short holds model glitches the filter must reject, long ones real edges
  task drive(input logic lvl, input int cyc);
    @(posedge clk);
    capture_pin <= lvl;
    repeat (cyc) @(posedge clk);
  endtask
endmodule // utcc_pin_model

// *** verif/utcc_timer_sva.sv ***
// Port-level assertion checker for the capture/compare timer
`include "utcc_defs.vh"
module utcc_timer_sva (
  input wire clk, // Timer clock
  input wire rst_n, // Sync reset, active low
  input wire [7:0] reg_addr, // Register address
  input wire [31:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [31:0] reg_rdata, // Read data
  input wire capture_pin, // Capture input
  input wire channel_output, // Compare output
  input wire update_event, // Update pulse
  input wire channel_irq // Channel request
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Copies of written controls
  // ----
  logic [31:0] ctl, chn, ien;
  logic [15:0] arr, psc;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctl <= 32'h0;
      chn <= 32'h0;
      ien <= 32'h0;
      arr <= 16'hFFFF;
      psc <= 16'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `UTCC_OFS_CONTROL_ONE) ctl <= reg_wdata;
      if (reg_addr == `UTCC_OFS_CHAN_CTRL) chn <= reg_wdata;
      if (reg_addr == `UTCC_OFS_IRQ_ENABLE) ien <= reg_wdata;
      if (reg_addr == `UTCC_OFS_RELOAD) arr <= reg_wdata[15:0];
      if (reg_addr == `UTCC_OFS_PRESCALE) psc <= reg_wdata[15:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  AST_EG_READ: assert property ($past(reg_rd && reg_addr == `UTCC_OFS_EVENT_GEN) |-> reg_rdata == 32'h0)
    else $error("event register not write only");
  AST_ARR_READ: assert property ($past(reg_rd && reg_addr == `UTCC_OFS_RELOAD) |-> reg_rdata == {16'h0, arr})
    else $error("reload read is not the preload");
  AST_PSC_READ: assert property ($past(reg_rd && reg_addr == `UTCC_OFS_PRESCALE) |-> reg_rdata == {16'h0, psc})
    else $error("prescaler read wrong");
  AST_SR_MASK: assert property ($past(reg_rd && reg_addr == `UTCC_OFS_STATUS) |-> (reg_rdata & 32'hFFFFFDFC) == 32'h0)
    else $error("status has stray bits");
  AST_UG_PULSE: assert property (reg_wr && reg_addr == `UTCC_OFS_EVENT_GEN && reg_wdata[0] && !ctl[1] |-> ##1 update_event)
    else $error("software update gave no pulse");
  AST_SUPPRESS: assert property (ctl[1] && $past(ctl[1]) && $past(ctl[1], 2) |-> !update_event)
    else $error("update while suppressed");
  AST_IRQ_MASK: assert property (!ien[1] && !$past(ien[1]) |-> !channel_irq)
    else $error("request while disabled");
  AST_FORCE: assert property (chn == $past(chn) && chn == $past(chn, 2) && chn == $past(chn, 3) && chn[1:0] == 2'h0
    && chn[11:9] == 3'h2 |-> channel_output == (chn[8] ^ chn[13]))
    else $error("forced output wrong");
endmodule // utcc_timer_sva
bind utcc_timer utcc_timer_sva chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .capture_pin, .channel_output, .update_event, .channel_irq);
